// *** status_display_formatter.sv ***
// status display formatter top
`timescale 1ns/1ps
`include "disp_map.svh"
module status_display_formatter
  import disp_pkg::*;
#(
  parameter int unsigned HALF_CYC = `HALF_SEC_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire ctl_state_t  ctl_state_i,
  input  wire logic        detail_sw_i,
  input  wire logic        comm_alive_i,
  input  wire logic        loaded_i,
  input  wire test_seq_t   test_seq_i,
  input  wire logic [15:0] comm_code_i,
  input  wire logic [15:0] ctrl_code_i,
  input  wire node_loc_t   node_loc_i,
  output disp_word_t       disp_o
);

  // ==========================================================
  // decode functions
  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'ha) ? (`CH_ZERO + {4'h0, v}) : (`CH_A + {4'h0, v} - 8'h0a);
  endfunction : hex_char

  function automatic logic [7:0] dec_char(input logic [6:0] v);
    dec_char = `CH_ZERO + {4'h0, v[3:0]};
  endfunction : dec_char

  // ==========================================================
  // sub-blocks
  logic       tick;
  logic       phase;
  logic       seq_run;
  logic       restart;
  fail_step_t step;

  blink_divider #(.HALF_CYC(HALF_CYC)) u_blink (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tick_o    (tick),
    .phase_o   (phase)
  );

  fail_sequencer u_seq (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .run_i     (seq_run),
    .restart_i (restart),
    .tick_i    (tick),
    .step_o    (step)
  );

  // ==========================================================
  // state tracking
  ctl_state_t state_q;
  logic       seen_q;
  logic       seen_d;

  assign seen_d  = seen_q | detail_sw_i;
  assign restart = (ctl_state_i != state_q);
  assign seq_run = (ctl_state_i == ST_FAIL) && seen_d && comm_alive_i;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_STARTUP;
      seen_q  <= 1'b0;
    end else begin
      state_q <= ctl_state_i;
      seen_q  <= seen_d;
    end
  end

  // ==========================================================
  // field decode
  logic [6:0] node_tens;
  logic [6:0] node_ones;
  logic [7:0] pos_ch;
  logic [7:0] tens_ch;
  logic [7:0] ones_ch;
  logic [7:0] test_hi;
  logic [7:0] test_lo;
  logic [7:0] test_num;
  logic [15:0] ctrl_shown;

  assign node_tens = node_loc_i.node / 7'd10;
  assign node_ones = node_loc_i.node - 7'(node_tens * 7'd10);
  assign tens_ch   = dec_char(node_tens);
  assign ones_ch   = dec_char(node_ones);
  assign pos_ch    = node_loc_i.long_file ? (node_loc_i.second ? `CH_TWO : `CH_ONE)
                                          : (node_loc_i.second ? `CH_R : `CH_L);
  assign test_num  = {test_seq_i.ctrl, test_seq_i.num};
  assign test_hi   = hex_char(test_num[7:4]);
  assign test_lo   = hex_char(test_num[3:0]);
  assign ctrl_shown = loaded_i ? ctrl_code_i : 16'h0000;

  // ==========================================================
  // fixed words
  disp_word_t w_blank;
  disp_word_t w_fail;
  disp_word_t w_idle;
  disp_word_t w_idle_soft;
  disp_word_t w_load;
  disp_word_t w_run;
  disp_word_t w_run_soft;
  disp_word_t w_strt;
  disp_word_t w_swap;
  disp_word_t w_sync;
  disp_word_t w_test;
  disp_word_t w_comm;
  disp_word_t w_ctrl;
  disp_word_t w_comm_code;
  disp_word_t w_ctrl_code;

  assign w_blank     = {`CH_BLANK, `CH_BLANK, `CH_BLANK, `CH_BLANK};
  assign w_fail      = {`CH_F, pos_ch, tens_ch, ones_ch};
  assign w_idle      = {`CH_I, `CH_BLANK, tens_ch, ones_ch};
  assign w_idle_soft = {`CH_I, `CH_S, tens_ch, ones_ch};
  assign w_load      = {`CH_L, pos_ch, tens_ch, ones_ch};
  assign w_run       = {`CH_O, `CH_K, tens_ch, ones_ch};
  assign w_run_soft  = {`CH_S, `CH_F, tens_ch, ones_ch};
  assign w_strt      = {`CH_S, `CH_T, `CH_R, `CH_T};
  assign w_swap      = {`CH_S, `CH_W, `CH_A, `CH_P};
  assign w_sync      = {`CH_S, `CH_Y, `CH_N, `CH_C};
  assign w_test      = {`CH_T, `CH_BLANK, test_hi, test_lo};
  assign w_comm      = {`CH_C, `CH_O, `CH_M, `CH_M};
  assign w_ctrl      = {`CH_C, `CH_T, `CH_R, `CH_L};
  assign w_comm_code = {hex_char(comm_code_i[15:12]), hex_char(comm_code_i[11:8]),
                        hex_char(comm_code_i[7:4]), hex_char(comm_code_i[3:0])};
  assign w_ctrl_code = {hex_char(ctrl_shown[15:12]), hex_char(ctrl_shown[11:8]),
                        hex_char(ctrl_shown[7:4]), hex_char(ctrl_shown[3:0])};

  // ==========================================================
  // message select
  disp_word_t fail_word;
  disp_word_t msg;
  logic       blinks;
  disp_word_t disp_d;

  always_comb begin
    case (step)
      FS_COMM_MARK: fail_word = w_comm;
      FS_COMM_CODE: fail_word = w_comm_code;
      FS_CTRL_MARK: fail_word = w_ctrl;
      FS_CTRL_CODE: fail_word = w_ctrl_code;
      FS_BLANK:     fail_word = w_blank;
      default:      fail_word = w_fail;
    endcase
  end

  always_comb begin
    blinks = 1'b0;
    case (ctl_state_i)
      ST_FAIL: begin
        msg    = seq_run ? fail_word : w_fail;
        blinks = !seq_run;
      end
      ST_IDLE:        msg = w_idle;
      ST_IDLE_SOFT:   msg = w_idle_soft;
      ST_LOAD: begin
        msg    = w_load;
        blinks = 1'b1;
      end
      ST_RUN:         msg = w_run;
      ST_RUN_SOFT:    msg = w_run_soft;
      ST_STARTUP:     msg = seen_d ? w_test : w_strt;
      ST_SWAP_TO_SEC: msg = seen_d ? w_test : w_swap;
      ST_SWAP_TO_PRI: msg = w_run;
      ST_SYNC:        msg = w_sync;
      default:        msg = w_blank;
    endcase
  end

  assign disp_d = (blinks && !phase) ? w_blank : msg;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disp_o <= {`CH_BLANK, `CH_BLANK, `CH_BLANK, `CH_BLANK};
    end else begin
      disp_o <= disp_d;
    end
  end

  // ==========================================================
  // checks
  run_steady_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_RUN)[*2] |=> disp_o.c3 == `CH_O && disp_o.c2 == `CH_K)
    else $error("run word missing or blinking");
  run_soft_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_RUN_SOFT |=> disp_o.c3 == `CH_S && disp_o.c2 == `CH_F)
    else $error("run soft word wrong");
  idle_word_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_IDLE |=> disp_o.c3 == `CH_I && disp_o.c2 == `CH_BLANK)
    else $error("idle word wrong");
  idle_soft_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_IDLE_SOFT |=> disp_o.c3 == `CH_I && disp_o.c2 == `CH_S)
    else $error("idle soft word wrong");
  load_blink_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_LOAD && !phase) |=> disp_o == w_blank)
    else $error("load word not blanked");
  fail_blink_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_FAIL && !seen_d && phase) |=> disp_o.c3 == `CH_F)
    else $error("fail word missing");
  strt_generic_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_STARTUP && !seen_d) |=> disp_o == w_strt)
    else $error("start text wrong");
  test_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    detail_sw_i |=> seen_q[*3]) else $error("detail flag lost");
  swap_test_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_SWAP_TO_SEC && seen_d) |=> disp_o.c3 == `CH_T)
    else $error("swap test number missing");
  sync_word_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_SYNC |=> disp_o == w_sync) else $error("sync text wrong");
  null_ctrl_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (step == FS_CTRL_CODE && seq_run && !loaded_i) |=> disp_o.c0 == `CH_ZERO)
    else $error("ctrl code not null");

  // ==========================================================
  // checks: more fixed words
  swap_pri_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_SWAP_TO_PRI |=> disp_o.c3 == `CH_O && disp_o.c2 == `CH_K)
    else $error("swap to primary shows a transition text");
  swap_generic_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_SWAP_TO_SEC && !seen_d) |=> disp_o == w_swap)
    else $error("swap text wrong");
  test_word_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_STARTUP && seen_d) |=> disp_o.c3 == `CH_T && disp_o.c2 == `CH_BLANK)
    else $error("test number word wrong");
  ctrl_test_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_STARTUP && seen_d && test_seq_i.ctrl)
    |=> disp_o.c1 inside {8'h38, 8'h39, [8'h41:8'h46]})
    else $error("control test number not marked");
  comm_test_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_STARTUP && seen_d && !test_seq_i.ctrl)
    |=> disp_o.c1 inside {[8'h30:8'h37]})
    else $error("comm test number marked as control");
  load_shown_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_LOAD && phase) |=> disp_o.c3 == `CH_L)
    else $error("load word missing");
  fail_blank_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_FAIL && !seq_run && !phase) |=> disp_o == w_blank)
    else $error("fail word not blanked");

  // ==========================================================
  // checks: node and position fields
  node_digits_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_RUN && node_loc_i.node inside {[7'd1:7'd64]})
    |=> disp_o.c1 inside {[8'h30:8'h36]} && disp_o.c0 inside {[8'h30:8'h39]})
    else $error("node digits out of range");
  pos_char_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ctl_state_i == ST_LOAD && phase)
    |=> disp_o.c2 inside {`CH_L, `CH_R, `CH_ONE, `CH_TWO})
    else $error("position character wrong");

  // ==========================================================
  // checks: fail sequence
  fail_head_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (seq_run && step == FS_FAIL) |=> disp_o.c3 == `CH_F)
    else $error("fail pattern missing in sequence");
  comm_code_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (seq_run && step == FS_COMM_CODE) |=> disp_o.c0 inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("comm code not hex");
  comm_mark_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (seq_run && step == FS_COMM_MARK) |=> disp_o.c3 == `CH_C && disp_o.c2 == `CH_O)
    else $error("comm marker wrong");
  ctrl_mark_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (seq_run && step == FS_CTRL_MARK) |=> disp_o.c3 == `CH_C && disp_o.c2 == `CH_T)
    else $error("ctrl marker wrong");
  seq_blank_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (seq_run && step == FS_BLANK) |=> disp_o == w_blank)
    else $error("sequence gap not blank");
  restart_step_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    restart |=> step == FS_FAIL)
    else $error("sequence not restarted");

  // ==========================================================
  // checks: blink period
  logic [31:0] ph_cnt_q;
  logic        phase_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph_cnt_q <= 32'h0;
      phase_q  <= 1'b0;
    end else begin
      ph_cnt_q <= (phase != phase_q) ? 32'h1 : ph_cnt_q + 32'h1;
      phase_q  <= phase;
    end
  end

  blink_period_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (phase != phase_q) == (ph_cnt_q == 32'(HALF_CYC)))
    else $error("blink phase period wrong");

  cov_fail_seq: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    step == FS_BLANK ##1 step == FS_FAIL);
  cov_load_blink: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_LOAD && tick);
  cov_test_num: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_STARTUP && seen_q);
  cov_detail_loaded: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    step == FS_CTRL_CODE && seq_run && loaded_i);
  cov_fail_dead: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_state_i == ST_FAIL && seen_d && !comm_alive_i);

endmodule : status_display_formatter

// *** disp_map.svh ***
// constants of the front-panel status display formatter
// Operation
// - fail state, switch not enabled since power-up: blinking F, position, node number
// - switch on after failure: alternate crash codes with fail pattern while comm alive
// - order fail, comm marker, comm code, ctrl marker, ctrl code, blank
// - before personality load the second processor code shows as null
// - idle state shows I, blank and node number
// - idle soft-fail state shows I, S and node number
// - loading shows L, position, node number, blinking each half second
// - run as primary shows O, K, node number, steady
// - run soft-fail shows S, F, node number, steady
// - startup shows steady start text, or test numbers when detailed
// - primary to secondary shows steady swap text, or test numbers when detailed
// - secondary to primary shows no intermediate message
// - synchronize shows steady sync text
// - test number shown as T and two hex digits
// - test numbers only once switch was enabled since power-up
// - test numbers kept distinct between the two processors
// - two rightmost characters carry node number 01 to 64 in decimal
// - position is L or R in short file, 1 or 2 in long backpanel
`ifndef DISP_MAP_SVH
`define DISP_MAP_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS 20
`define HALF_SEC_NS   500000000
`define HALF_SEC_CYC  (`HALF_SEC_NS / `CLK_PERIOD_NS)

// ==========================================================
// characters
`define CH_BLANK 8'h20
`define CH_DASH  8'h2d
`define CH_ZERO  8'h30
`define CH_A     8'h41
`define CH_C     8'h43
`define CH_F     8'h46
`define CH_I     8'h49
`define CH_K     8'h4b
`define CH_L     8'h4c
`define CH_M     8'h4d
`define CH_N     8'h4e
`define CH_O     8'h4f
`define CH_P     8'h50
`define CH_R     8'h52
`define CH_S     8'h53
`define CH_T     8'h54
`define CH_W     8'h57
`define CH_Y     8'h59
`define CH_ONE   8'h31
`define CH_TWO   8'h32

// ==========================================================
// test number split between processors
`define TEST_CTRL_BIT 7

`endif

// *** disp_pkg.sv ***
// types of the front-panel status display formatter
package disp_pkg;

  typedef enum logic [3:0] {
    ST_FAIL,
    ST_IDLE,
    ST_IDLE_SOFT,
    ST_LOAD,
    ST_RUN,
    ST_RUN_SOFT,
    ST_STARTUP,
    ST_SWAP_TO_SEC,
    ST_SWAP_TO_PRI,
    ST_SYNC
  } ctl_state_t;

  typedef enum logic [2:0] {
    FS_FAIL,
    FS_COMM_MARK,
    FS_COMM_CODE,
    FS_CTRL_MARK,
    FS_CTRL_CODE,
    FS_BLANK
  } fail_step_t;

  typedef struct packed {
    logic [7:0] c3;
    logic [7:0] c2;
    logic [7:0] c1;
    logic [7:0] c0;
  } disp_word_t;

  typedef struct packed {
    logic       long_file;
    logic       second;
    logic [6:0] node;
  } node_loc_t;

  typedef struct packed {
    logic       ctrl;
    logic [6:0] num;
  } test_seq_t;

endpackage : disp_pkg

// *** blink_divider.sv ***
// half-second blink divider
`timescale 1ns/1ps
`include "disp_map.svh"
module blink_divider
  import disp_pkg::*;
#(
  parameter int unsigned HALF_CYC = `HALF_SEC_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  output logic      tick_o,
  output logic      phase_o
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        wrap;

  assign wrap  = (cnt_q == 32'(HALF_CYC - 1));
  assign cnt_d = wrap ? 32'h0 : cnt_q + 32'h1;

  // ==========================================================
  // divider, restarts blank
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q   <= 32'h0;
      phase_o <= 1'b0;
      tick_o  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      tick_o  <= wrap;
      phase_o <= phase_o ^ wrap;
    end
  end

  tick_spacing_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    tick_o |=> !tick_o) else $error("blink tick longer than a cycle");

endmodule : blink_divider

// *** fail_sequencer.sv ***
// detailed fail sequence step counter
`timescale 1ns/1ps
module fail_sequencer
  import disp_pkg::*;
(
  input  wire logic  clk_sys_i,
  input  wire logic  resetn_i,
  input  wire logic  run_i,
  input  wire logic  restart_i,
  input  wire logic  tick_i,
  output fail_step_t step_o
);

  fail_step_t step_d;

  assign step_d = (restart_i || !run_i) ? FS_FAIL :
                  !tick_i               ? step_o  :
                  (step_o == FS_BLANK)  ? FS_FAIL : fail_step_t'(step_o + 3'h1);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step_o <= FS_FAIL;
    end else begin
      step_o <= step_d;
    end
  end

  step_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!tick_i && !restart_i && run_i) |=> $stable(step_o)) else $error("step moved early");
  step_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (step_o == FS_BLANK && tick_i) |=> step_o == FS_FAIL) else $error("no wrap");

endmodule : fail_sequencer

// *** disp_panel_model.sv ***
// front-panel display model: latches the shown word and counts blinks
`timescale 1ns/1ps
module disp_panel_model
  import disp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire disp_word_t word_i,
  output disp_word_t      shown_o,
  output logic [15:0]     blinks_o
);
  // ==========================================================
  // panel latch and blank-to-text counter
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shown_o  <= 32'h20202020;
      blinks_o <= 16'h0;
    end else begin
      shown_o <= word_i;
      if (shown_o == 32'h20202020 && word_i != 32'h20202020) begin
        blinks_o <= blinks_o + 16'h1;
      end
    end
  end
endmodule : disp_panel_model

// *** status_display_formatter_tb_top.sv ***
// testbench of the status display formatter
`timescale 1ns/1ps
module status_display_formatter_tb_top;
  import disp_pkg::*;
  localparam int unsigned HC = 8;
  logic        clk_sys_i;
  logic        resetn_i;
  ctl_state_t  ctl_state_i;
  logic        detail_sw_i;
  logic        comm_alive_i;
  logic        loaded_i;
  test_seq_t   test_seq_i;
  logic [15:0] comm_code_i;
  logic [15:0] ctrl_code_i;
  node_loc_t   node_loc_i;
  disp_word_t  disp_o;
  disp_word_t  shown;
  logic [15:0] blinks;
  int          err_count;
  int          n_checks;

  // ==========================================================
  // clock, design and panel
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  status_display_formatter #(.HALF_CYC(HC)) dut (
    .clk_sys_i    (clk_sys_i),
    .resetn_i     (resetn_i),
    .ctl_state_i  (ctl_state_i),
    .detail_sw_i  (detail_sw_i),
    .comm_alive_i (comm_alive_i),
    .loaded_i     (loaded_i),
    .test_seq_i   (test_seq_i),
    .comm_code_i  (comm_code_i),
    .ctrl_code_i  (ctrl_code_i),
    .node_loc_i   (node_loc_i),
    .disp_o       (disp_o)
  );

  disp_panel_model panel (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .word_i    (disp_o),
    .shown_o   (shown),
    .blinks_o  (blinks)
  );

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic steady(input ctl_state_t st, input logic [31:0] exp);
    logic [31:0] seen;
    logic [15:0] b0;
    @(negedge clk_sys_i);
    ctl_state_i = st;
    repeat (3) @(negedge clk_sys_i);
    seen = exp;
    b0 = blinks;
    repeat (20) begin
      @(negedge clk_sys_i);
      if (shown !== exp) seen = shown;
    end
    check(seen, exp);
    check({16'h0, blinks - b0}, 32'h0);
    $display("test steady %s done", st.name());
  endtask : steady

  task automatic blinking(input ctl_state_t st, input logic [31:0] exp);
    logic [31:0] seen;
    logic [15:0] b0;
    @(negedge clk_sys_i);
    ctl_state_i = st;
    repeat (3) @(negedge clk_sys_i);
    seen = exp;
    b0 = blinks;
    repeat (2 * HC + 4) begin
      @(negedge clk_sys_i);
      if (shown !== exp && shown !== "    ") seen = shown;
    end
    check(seen, exp);
    check({31'h0, blinks != b0}, 32'h1);
    $display("test blink %s done", st.name());
  endtask : blinking

  task automatic detailed_fail(input logic ld, input logic [31:0] ctrl_exp);
    logic [31:0] seq [7];
    logic [31:0] prev;
    int          n;
    seq = '{"COMM", "AB12", "CTRL", ctrl_exp, "    ", "FR07", "COMM"};
    loaded_i   = ld;
    node_loc_i = '{long_file: 1'b0, second: 1'b1, node: 7'd7};
    steady(ST_IDLE, "I 07");
    ctl_state_i = ST_FAIL;
    detail_sw_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check(shown, "FR07");
    for (int i = 0; i < 7; i++) begin
      prev = shown;
      n = 0;
      while (shown === prev && n < 5 * HC) begin
        @(negedge clk_sys_i);
        n++;
      end
      check(shown, seq[i]);
      if (i == 1) check(n, HC);
    end
    ctl_state_i = ST_RUN;
    @(negedge clk_sys_i);
    ctl_state_i = ST_FAIL;
    repeat (3) @(negedge clk_sys_i);
    check(shown, "FR07");
    detail_sw_i = 1'b0;
    loaded_i    = 1'b0;
    $display("test detailed fail done");
  endtask : detailed_fail

  // ==========================================================
  // main sequence
  initial begin
    err_count    = 0;
    n_checks     = 0;
    resetn_i     = 1'b0;
    ctl_state_i  = ST_STARTUP;
    detail_sw_i  = 1'b0;
    comm_alive_i = 1'b1;
    loaded_i     = 1'b0;
    test_seq_i   = '{ctrl: 1'b1, num: 7'h05};
    comm_code_i  = 16'hab12;
    ctrl_code_i  = 16'h5555;
    node_loc_i   = '{long_file: 1'b0, second: 1'b0, node: 7'd7};
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(disp_o, "    ");
    resetn_i = 1'b1;
    steady(ST_STARTUP, "STRT");
    steady(ST_SWAP_TO_SEC, "SWAP");
    steady(ST_IDLE, "I 07");
    steady(ST_IDLE_SOFT, "IS07");
    steady(ST_RUN_SOFT, "SF07");
    steady(ST_SYNC, "SYNC");
    steady(ST_SWAP_TO_PRI, "OK07");
    node_loc_i = '{long_file: 1'b1, second: 1'b0, node: 7'd64};
    steady(ST_RUN, "OK64");
    blinking(ST_LOAD, "L164");
    node_loc_i = '{long_file: 1'b1, second: 1'b1, node: 7'd33};
    blinking(ST_LOAD, "L233");
    node_loc_i = '{long_file: 1'b0, second: 1'b0, node: 7'd12};
    blinking(ST_FAIL, "FL12");
    node_loc_i = '{long_file: 1'b0, second: 1'b1, node: 7'd7};
    blinking(ST_FAIL, "FR07");
    detailed_fail(1'b0, "0000");
    comm_alive_i = 1'b0;
    blinking(ST_FAIL, "FR07");
    comm_alive_i = 1'b1;
    detailed_fail(1'b1, "5555");
    steady(ST_STARTUP, "T 85");
    test_seq_i = '{ctrl: 1'b0, num: 7'h3c};
    steady(ST_SWAP_TO_SEC, "T 3C");
    @(negedge clk_sys_i);
    resetn_i = 1'b0;
    @(negedge clk_sys_i);
    check(disp_o, "    ");
    resetn_i = 1'b1;
    steady(ST_STARTUP, "STRT");
    report_and_stop();
  end

  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    report_and_stop();
  end
endmodule : status_display_formatter_tb_top
